// ==== common/olm_pkg.sv ====
// Purpose: shared constants and types of the output cell array
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   the stored architecture word is 82 bits wide in three words
package olm_pkg;

    localparam int NUM_CELLS = 8;
    localparam int ARCH_BITS = 82;
    localparam int ADDR_W    = 8;

    // programming-map row of the architecture word
    localparam logic [7:0] ARCH_ROW = 8'h3C;

    // byte offsets of the registers
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CHECK_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] ARCH0_OFS  = {ARCH_ROW[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ARCH1_OFS  = ARCH0_OFS + 8'h04;
    localparam logic [ADDR_W-1:0] ARCH2_OFS  = ARCH0_OFS + 8'h08;

    // field positions inside the architecture word
    localparam int POL_LSB    = 0;
    localparam int CELL_LSB   = 8;
    localparam int SHARED_POS = 16;
    localparam int GLOBAL_POS = 17;
    localparam int ARCH2_W    = ARCH_BITS - 64;

    // reset values
    localparam logic [31:0]        ARCH_WORD_RST = 32'h0000_0000;
    localparam logic [ARCH2_W-1:0] ARCH2_RST     = 18'h0_0000;
    localparam logic [NUM_CELLS-1:0] REG_Q_RST   = 8'h00;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OLM_INVALID   = 3'b000,
        OLM_SIMPLE_OUT = 3'b001,
        OLM_SIMPLE_IN = 3'b010,
        OLM_COMPLEX   = 3'b011,
        OLM_REGISTERED = 3'b100,
        OLM_COMB_IN_REG = 3'b101
    } olm_mode_t;

    // architecture word, least significant field last
    typedef struct packed {
        logic [63:0]          spare;
        logic                 global_registered_select;
        logic                 shared_arch_bit;
        logic [NUM_CELLS-1:0] per_cell_arch_bit;
        logic [NUM_CELLS-1:0] polarity;
    } olm_arch_t;

    // all pads as seen by the core, one bit per cell
    typedef struct packed {
        logic [NUM_CELLS-1:0] o;
        logic [NUM_CELLS-1:0] oe;
    } olm_pad_t;

endpackage

// ==== hw/olm_top.sv ====
// Purpose: eight configurable output cells behind an AXI4-Lite register file
// Assumes: sums and enable terms come from array logic on aclk
// Notes:   pins and the device clock pin are synchronised by three flops
`timescale 1ns/100ps

module olm_top
(
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    input  wire logic [olm_pkg::ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [olm_pkg::ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    input  wire logic                             dev_clk_pin,
    input  wire logic                             common_oe_n,
    input  wire logic [olm_pkg::NUM_CELLS-1:0]    sum_terms,
    input  wire logic [olm_pkg::NUM_CELLS-1:0]    oe_terms,
    input  wire logic [olm_pkg::NUM_CELLS-1:0]    pad_i,
    output olm_pkg::olm_pad_t                     pad,
    output logic [olm_pkg::NUM_CELLS-1:0]         feedback
);

    localparam int N = olm_pkg::NUM_CELLS;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // only five combinations decode to a working cell
    function automatic olm_pkg::olm_mode_t decode(input logic g,
                                                   input logic s,
                                                   input logic c);
        olm_pkg::olm_mode_t m;
        case ({g, s, c})
            3'b100:  m = olm_pkg::OLM_SIMPLE_OUT;
            3'b101:  m = olm_pkg::OLM_SIMPLE_IN;
            3'b111:  m = olm_pkg::OLM_COMPLEX;
            3'b010:  m = olm_pkg::OLM_REGISTERED;
            3'b011:  m = olm_pkg::OLM_COMB_IN_REG;
            default: m = olm_pkg::OLM_INVALID;
        endcase
        return m;
    endfunction

    // ---- architecture word storage
    logic [31:0]                  arch0_q;
    logic [31:0]                  arch1_q;
    logic [olm_pkg::ARCH2_W-1:0]  arch2_q;
    olm_pkg::olm_arch_t           arch;

    assign arch = olm_pkg::olm_arch_t'({arch2_q, arch1_q, arch0_q});

    // ---- pin synchronisers
    logic [N+1:0] sync1_q;
    logic [N+1:0] sync2_q;
    logic [N+1:0] sync3_q;
    logic [N+1:0] pins_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pins_q  <= {1'b0, 1'b1, {N{1'b0}}};
        end
        else
        begin
            sync1_q <= {dev_clk_pin, common_oe_n, pad_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int k = 0; k < N + 2; k++)
            begin
                if (sync2_q[k] == sync3_q[k])
                begin
                    pins_q[k] <= sync3_q[k];
                end
            end
        end
    end

    logic [N-1:0] pin_s;
    logic         oe_n_s;
    logic         clk_s;
    logic         clk_prev_q;
    logic         clk_rise;

    assign pin_s    = pins_q[N-1:0];
    assign oe_n_s   = pins_q[N];
    assign clk_s    = pins_q[N+1];
    assign clk_rise = clk_s & ~clk_prev_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_prev_q <= 1'b0;
        end
        else
        begin
            clk_prev_q <= clk_s;
        end
    end

    // ---- per cell decode
    olm_pkg::olm_mode_t mode [N];
    logic [N-1:0]       pv;
    logic [N-1:0]       nsel;

    always_comb
    begin
        logic s_eff;
        s_eff = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            s_eff = arch.shared_arch_bit;
            if (i == 0 || i == N - 1)
            begin
                s_eff   = arch.global_registered_select;
                nsel[i] = ~arch.global_registered_select;
            end
            else
            begin
                nsel[i] = arch.per_cell_arch_bit[(i < N/2) ? i + 1 : i - 1];
            end
            mode[i] = decode(arch.global_registered_select,
                             s_eff, arch.per_cell_arch_bit[i]);
            pv[i] = sum_terms[i] ^ ~arch.polarity[i];
        end
    end

    // ---- output registers and pad drivers
    logic [N-1:0] reg_q;
    olm_pkg::olm_pad_t pad_q;
    logic [N-1:0] fb_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reg_q <= olm_pkg::REG_Q_RST;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (mode[i] == olm_pkg::OLM_REGISTERED && clk_rise)
                begin
                    reg_q[i] <= ~pv[i];
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_q <= '0;
            fb_q  <= '0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                case (mode[i])
                    olm_pkg::OLM_SIMPLE_OUT:
                    begin
                        pad_q.o[i]  <= pv[i];
                        pad_q.oe[i] <= 1'b1;
                        fb_q[i]     <= nsel[i] ? pin_s[(i < N/2) ? i + 1 : i - 1]
                                               : 1'b0;
                    end
                    olm_pkg::OLM_SIMPLE_IN:
                    begin
                        pad_q.o[i]  <= 1'b0;
                        pad_q.oe[i] <= 1'b0;
                        fb_q[i]     <= pin_s[i];
                    end
                    olm_pkg::OLM_COMPLEX,
                    olm_pkg::OLM_COMB_IN_REG:
                    begin
                        pad_q.o[i]  <= pv[i];
                        pad_q.oe[i] <= oe_terms[i];
                        // outer cells gate their own pin by the select
                        fb_q[i]     <= (i == 0 || i == N - 1)
                                       ? nsel[i] & pin_s[i]
                                       : pin_s[i];
                    end
                    olm_pkg::OLM_REGISTERED:
                    begin
                        pad_q.o[i]  <= ~reg_q[i];
                        pad_q.oe[i] <= ~oe_n_s;
                        fb_q[i]     <= ~reg_q[i];
                    end
                    default:
                    begin
                        pad_q.o[i]  <= 1'b0;
                        pad_q.oe[i] <= 1'b0;
                        fb_q[i]     <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign pad      = pad_q;
    assign feedback = fb_q;

    // ---- AXI4-Lite slave
    logic                        aw_hold_q;
    logic                        w_hold_q;
    logic [olm_pkg::ADDR_W-1:0]  awaddr_q;
    logic [31:0]                 wdata_q;
    logic [3:0]                  wstrb_q;
    logic                        do_write;

    logic                        aw_hold_d;
    logic                        w_hold_d;
    logic                        bvalid_d;

    assign do_write  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    assign aw_hold_d = ~do_write
                       & (aw_hold_q | (s_axi_awvalid & s_axi_awready));
    assign w_hold_d  = ~do_write
                       & (w_hold_q | (s_axi_wvalid & s_axi_wready));
    assign bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);

    // readies come from flops and show the state after this edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= ~aw_hold_d & ~bvalid_d;
            s_axi_wready  <= ~w_hold_d & ~bvalid_d;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            awaddr_q     <= '0;
            wdata_q      <= '0;
            wstrb_q      <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= olm_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == olm_pkg::ARCH0_OFS ||
                                 awaddr_q == olm_pkg::ARCH1_OFS ||
                                 awaddr_q == olm_pkg::ARCH2_OFS)
                                ? olm_pkg::RESP_OKAY : olm_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arch0_q <= olm_pkg::ARCH_WORD_RST;
            arch1_q <= olm_pkg::ARCH_WORD_RST;
            arch2_q <= olm_pkg::ARCH2_RST;
        end
        else if (do_write)
        begin
            case (awaddr_q)
                olm_pkg::ARCH0_OFS: arch0_q <= merge(arch0_q, wdata_q, wstrb_q);
                olm_pkg::ARCH1_OFS: arch1_q <= merge(arch1_q, wdata_q, wstrb_q);
                olm_pkg::ARCH2_OFS:
                    arch2_q <= olm_pkg::ARCH2_W'(merge({14'h0000, arch2_q},
                                                       wdata_q, wstrb_q));
                default: ;
            endcase
        end
    end

    logic [N-1:0] invalid;

    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            invalid[i] = (mode[i] == olm_pkg::OLM_INVALID);
        end
    end

    logic rvalid_d;

    assign rvalid_d = (s_axi_arvalid & s_axi_arready)
                      | (s_axi_rvalid & ~s_axi_rready);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
        end
        else
        begin
            s_axi_arready <= ~rvalid_d;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= olm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= olm_pkg::RESP_OKAY;
            case (s_axi_araddr)
                olm_pkg::STATUS_OFS: s_axi_rdata <= {8'h00, pad_q.oe, pad_q.o, reg_q};
                olm_pkg::CHECK_OFS:  s_axi_rdata <= {24'h000000, invalid};
                olm_pkg::ARCH0_OFS:  s_axi_rdata <= arch0_q;
                olm_pkg::ARCH1_OFS:  s_axi_rdata <= arch1_q;
                olm_pkg::ARCH2_OFS:  s_axi_rdata <= {14'h0000, arch2_q};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= olm_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---- assertions
    sequence s_clock_rise;
        clk_s && !clk_prev_q;
    endsequence

    a_reset_clears_regs: assert property (@(posedge aclk)
        !aresetn |=> reg_q == 8'h00)
        else $error("output registers not cleared by reset");

    a_outer_no_shared: assert property (@(posedge aclk) disable iff (!aresetn)
        !arch.global_registered_select |->
        mode[0] == olm_pkg::OLM_INVALID)
        else $error("outer cell ignores global bit in place of shared bit");

    a_outer_fb_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        mode[0] == olm_pkg::OLM_COMPLEX |=> !fb_q[0])
        else $error("outer cell feeds back its pin in complex mode");

    for (genvar g = 0; g < N; g++)
    begin : g_chk
        a_reg_capture_edge: assert property (@(posedge aclk)
            disable iff (!aresetn)
            (mode[g] == olm_pkg::OLM_REGISTERED) and s_clock_rise
            |=> reg_q[g] == !$past(pv[g]))
            else $error("registered cell missed clock rise");

        a_reg_hold_state: assert property (@(posedge aclk)
            disable iff (!aresetn)
            !clk_rise |=> $stable(reg_q[g]))
            else $error("register changed without clock rise");

        a_comb_polarity: assert property (@(posedge aclk)
            disable iff (!aresetn)
            mode[g] == olm_pkg::OLM_COMPLEX
            |=> pad_q.o[g] == ($past(sum_terms[g]) ~^ $past(arch.polarity[g])))
            else $error("combinational output polarity wrong");

        a_input_driver_off: assert property (@(posedge aclk)
            disable iff (!aresetn)
            mode[g] == olm_pkg::OLM_SIMPLE_IN
            |=> !pad_q.oe[g] && fb_q[g] == $past(pin_s[g]))
            else $error("input cell drives pin or drops feedback");

        a_always_on_oe: assert property (@(posedge aclk)
            disable iff (!aresetn)
            mode[g] == olm_pkg::OLM_SIMPLE_OUT |=> pad_q.oe[g])
            else $error("simple output not always enabled");

        a_common_oe_pin: assert property (@(posedge aclk)
            disable iff (!aresetn)
            mode[g] == olm_pkg::OLM_REGISTERED
            |=> pad_q.oe[g] == !$past(oe_n_s))
            else $error("registered cell not on common enable");

        a_term_oe_feedback: assert property (@(posedge aclk)
            disable iff (!aresetn)
            mode[g] == olm_pkg::OLM_COMB_IN_REG
            |=> pad_q.oe[g] == $past(oe_terms[g]) && fb_q[g] == $past(pin_s[g]))
            else $error("term enable or pin feedback wrong");

        a_reg_feedback_inv: assert property (@(posedge aclk)
            disable iff (!aresetn)
            mode[g] == olm_pkg::OLM_REGISTERED
            |=> fb_q[g] == !$past(reg_q[g]))
            else $error("registered feedback not inverted state");
    end

endmodule

// ==== verif/olm_board.sv ====
// Purpose: board around the output cells: pin levels and device clock
// Assumes: the board drives every pin that the cells leave released
// Notes:   one request gives one device clock pulse of eight aclk cycles
`timescale 1ns/100ps

module olm_board
(
    input  wire logic              aclk,
    input  wire olm_pkg::olm_pad_t pad,
    input  wire logic [7:0]        ext_level,
    input  wire logic              clk_req,
    output logic [7:0]             pad_i,
    output logic                   dev_clk_pin
);
    logic [3:0] hold_q = 4'h0;

    // released pins take the board level, driven pins the cell value
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            pad_i[i] = pad.oe[i] ? pad.o[i] : ext_level[i];
    end

    // the device clock stays low outside a requested pulse
    always_ff @(posedge aclk)
    begin
        if (clk_req)
            hold_q <= 4'h8;
        else if (hold_q != 4'h0)
            hold_q <= hold_q - 4'h1;
    end

    assign dev_clk_pin = (hold_q != 4'h0);
endmodule

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench of the output cell array
// Assumes: registers reached over AXI4-Lite, pins through the board model
// Notes:   expected pin values come from a cell model kept in the bench
`timescale 1ns/100ps

module tb_top;
    localparam logic [7:0] ROW_ADDR = 8'hF0; // row 60, one word per index
    logic aclk = 1'b0, aresetn = 1'b0, coe_n = 1'b0, clk_req = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [7:0] sum = 8'h00, oet = 8'h00, ext = 8'h00, rq = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic [3:0] wstrb = 4'h0;
    logic [17:0] cfg = 18'h0;
    logic [1:0] resp, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, dev_clk;
    logic [31:0] rdata;
    logic [7:0] fb, pad_i;
    olm_pkg::olm_pad_t pad;
    int bad_count = 0, n_checks = 0, cyc = 0;
    logic [23:0] pats [4] = '{24'hFF00AA, 24'h5AFF55, 24'hC33C0F, 24'h00A5F0};

    always #2.5 aclk = ~aclk;

    olm_top i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dev_clk_pin(dev_clk), .common_oe_n(coe_n), .sum_terms(sum),
        .oe_terms(oet), .pad_i(pad_i), .pad(pad), .feedback(fb));

    olm_board i_board (.aclk(aclk), .pad(pad), .ext_level(ext),
        .clk_req(clk_req), .pad_i(pad_i), .dev_clk_pin(dev_clk));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            $display("Error %0t run did not finish in time", $time);
            report_and_stop();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %0t response got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // expected {registered, invalid, o, oe, feedback} of all cells
    function automatic logic [39:0] model(input logic [17:0] w,
        input logic [7:0] s, input logic [7:0] t, input logic [7:0] x,
        input logic cn, input logic [7:0] q);
        logic [7:0] o, e, f, v, r, p;
        logic g, sel, outer;
        logic [2:0] m;
        int n;
        o = 8'h00;
        e = 8'h00;
        f = 8'h00;
        v = 8'h00;
        r = 8'h00;
        g = w[17];
        for (int i = 0; i < 8; i++)
        begin
            outer = (i == 0 || i == 7);
            m = {g, outer ? g : w[16], w[8+i]};
            case (m)
                3'b100, 3'b111, 3'b011:
                begin
                    o[i] = w[i] ? s[i] : ~s[i];
                    e[i] = (m == 3'b100) ? 1'b1 : t[i];
                end
                3'b010:
                begin
                    o[i] = ~q[i];
                    e[i] = ~cn;
                    r[i] = 1'b1;
                end
                3'b101: ;
                default: v[i] = 1'b1;
            endcase
        end
        p = (e & o) | (~e & x);
        for (int i = 0; i < 8; i++)
        begin
            outer = (i == 0 || i == 7);
            n = (i < 4) ? i + 1 : i - 1;
            sel = outer ? ~g : w[8+n];
            m = {g, outer ? g : w[16], w[8+i]};
            if (m == 3'b100)
                f[i] = sel & p[n];
            else if (m == 3'b010)
                f[i] = ~q[i];
            else if (v[i] == 1'b0)
                f[i] = (outer ? sel : 1'b1) & p[i];
        end
        return {r, v, o, e, f};
    endfunction

    task automatic check_cells();
        logic [39:0] x;
        repeat (12) @(posedge aclk);
        x = model(cfg, sum, oet, ext, coe_n, rq);
        chk_word({24'h0, pad.oe}, {24'h0, x[15:8]});
        chk_word({24'h0, pad.o & x[15:8]}, {24'h0, x[23:16] & x[15:8]});
        chk_word({24'h0, fb}, {24'h0, x[7:0]});
        axi_read(olm_pkg::CHECK_OFS, rd, resp);
        chk_word(rd, {24'h0, x[31:24]});
        axi_read(olm_pkg::STATUS_OFS, rd, resp);
        chk_word({8'h0, rd[23:16], rd[15:8] & x[15:8], rd[7:0]},
                 {8'h0, x[15:8], x[23:16] & x[15:8], rq});
    endtask

    task automatic dev_pulse();
        logic [39:0] x;
        x = model(cfg, sum, oet, ext, coe_n, rq);
        rq = (rq & ~x[39:32]) | (x[39:32] & (sum ^ cfg[7:0]));
        @(posedge aclk);
        clk_req <= 1'b1;
        @(posedge aclk);
        clk_req <= 1'b0;
        repeat (20) @(posedge aclk);
    endtask

    task automatic set_cfg(input logic [17:0] c);
        cfg = c;
        axi_write(ROW_ADDR, {14'h0, c}, 4'hF, resp);
        chk_resp(resp, olm_pkg::RESP_OKAY);
    endtask

    task automatic run_pats();
        for (int k = 0; k < 4; k++)
        begin
            @(posedge aclk);
            {sum, oet, ext} <= pats[k];
            check_cells();
        end
    endtask

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            axi_read(ROW_ADDR + 8'(4 * k), rd, resp);
            chk_word(rd, 32'h0000_0000);
        end
        check_cells();
        $display("test reset state done");
        axi_write(ROW_ADDR + 8'h08, 32'hFFFF_FFFF, 4'hF, resp);
        axi_read(ROW_ADDR + 8'h08, rd, resp);
        chk_word(rd, 32'h0003_FFFF);
        axi_write(ROW_ADDR + 8'h04, 32'hA5A5_5A5A, 4'hF, resp);
        axi_read(ROW_ADDR + 8'h04, rd, resp);
        chk_word(rd, 32'hA5A5_5A5A);
        axi_write(ROW_ADDR, 32'h1234_5678, 4'h1, resp);
        axi_read(ROW_ADDR, rd, resp);
        chk_word(rd, 32'h0000_0078);
        axi_write(8'h08, 32'h0000_0001, 4'hF, resp);
        chk_resp(resp, olm_pkg::RESP_SLVERR);
        axi_read(8'h08, rd, resp);
        chk_resp(resp, olm_pkg::RESP_SLVERR);
        chk_word(rd, 32'h0000_0000);
        $display("test register map done");
        set_cfg({1'b1, 1'b0, 8'hD3, 8'h0F});
        run_pats();
        set_cfg({1'b1, 1'b0, 8'hD3, 8'hF0});
        run_pats();
        $display("test combinational device done");
        set_cfg({1'b0, 1'b1, 8'h54, 8'hA5});
        check_cells();
        dev_pulse();
        check_cells();
        @(posedge aclk);
        sum <= ~sum;
        check_cells();
        dev_pulse();
        check_cells();
        @(posedge aclk);
        coe_n <= 1'b1;
        check_cells();
        $display("test registered device done");
        report_and_stop();
    end
endmodule
